//--- jtp_dev_end.sv
// Device end of the test access port: TAP controller, IR and DRs.
// Assumes everything here runs on the link's TCK; user ports are
// in the TCK domain, so user logic on another clock must sync them.
//
// Overview of operation
// - Shift TDI in on rising TCK
// - Change TDO on falling TCK
// - Release TDO unless shifting
// - Sample TMS on rising TCK
// - Host sets TMS up before rising TCK
// - State changes on following falling TCK
// - Test reset acts at once, no clock
// - Works with or without test reset
// - Host holds TMS high releasing reset
// - Host keeps pins stable during configuration
`timescale 1ns/1ps
module jtp_dev_end
	import jtp_pkg::*;
#(
	// Arbitrary identification value, lsb set as the standard needs
	parameter logic [DR_W-1:0] IDCODE_VAL = 32'h0ABC_D001
) (
	jtp_link_if.dev              lnk,
	input  wire logic [DR_W-1:0] i_user_capture,
	output logic [DR_W-1:0]      o_user_data,
	output logic                 o_user_stb,
	output logic [IR_W-1:0]      o_ir,
	output jtp_tap_t             o_tap_state
);

	// Rising-edge state: sampled TMS and the shift paths
	typedef struct packed {
		logic            tms;
		logic [IR_W-1:0] ir_sh;
		logic [DR_W-1:0] dr_sh;
	} jtp_rise_t;

	// Falling-edge state: controller, held registers and TDO pin
	typedef struct packed {
		jtp_tap_t        st;
		logic [IR_W-1:0] ir;
		logic [DR_W-1:0] upd;
		logic            upd_stb;
		logic            tdo;
		logic            oe;
	} jtp_fall_t;

	// TMS resets high so an idle link stays in reset
	localparam jtp_rise_t RISE_RST = '{
		tms:   1'b1,
		ir_sh: '0,
		dr_sh: '0
	};
	localparam jtp_fall_t FALL_RST = '{
		st:      TAP_RESET,
		ir:      INS_IDCODE,
		upd:     '0,
		upd_stb: 1'b0,
		tdo:     1'b0,
		oe:      1'b0
	};

	jtp_rise_t r_q;
	jtp_rise_t r_d;
	jtp_fall_t f_q;
	jtp_fall_t f_d;
	logic      bypass;

	function automatic jtp_tap_t tap_next(input jtp_tap_t s, input logic tms);
		jtp_tap_t n;
		n = s;
		case (s)
			TAP_RESET: begin
				n = tms ? TAP_RESET : TAP_IDLE;
			end
			TAP_IDLE: begin
				n = tms ? SEL_DR : TAP_IDLE;
			end
			SEL_DR: begin
				n = tms ? SEL_IR : CAP_DR;
			end
			CAP_DR: begin
				n = tms ? EX1_DR : SH_DR;
			end
			SH_DR: begin
				n = tms ? EX1_DR : SH_DR;
			end
			EX1_DR: begin
				n = tms ? UPD_DR : PAU_DR;
			end
			PAU_DR: begin
				n = tms ? EX2_DR : PAU_DR;
			end
			EX2_DR: begin
				n = tms ? UPD_DR : SH_DR;
			end
			UPD_DR: begin
				n = tms ? SEL_DR : TAP_IDLE;
			end
			SEL_IR: begin
				n = tms ? TAP_RESET : CAP_IR;
			end
			CAP_IR: begin
				n = tms ? EX1_IR : SH_IR;
			end
			SH_IR: begin
				n = tms ? EX1_IR : SH_IR;
			end
			EX1_IR: begin
				n = tms ? UPD_IR : PAU_IR;
			end
			PAU_IR: begin
				n = tms ? EX2_IR : PAU_IR;
			end
			EX2_IR: begin
				n = tms ? UPD_IR : SH_IR;
			end
			UPD_IR: begin
				n = tms ? SEL_DR : TAP_IDLE;
			end
			default: begin
				n = TAP_RESET;
			end
		endcase
		return n;
	endfunction

	// Unknown instructions select the one-bit bypass path
	assign bypass = (f_q.ir != INS_IDCODE) && (f_q.ir != INS_USER);

	always_comb begin
		r_d     = r_q;
		r_d.tms = lnk.tms;
		case (f_q.st)
			CAP_IR: begin
				r_d.ir_sh = IR_CAPTURE;
			end
			SH_IR: begin
				r_d.ir_sh = {lnk.tdi, r_q.ir_sh[IR_W-1:1]};
			end
			CAP_DR: begin
				if (f_q.ir == INS_IDCODE) begin
					r_d.dr_sh = IDCODE_VAL;
				end else if (f_q.ir == INS_USER) begin
					r_d.dr_sh = i_user_capture;
				end else begin
					r_d.dr_sh = '0;
				end
			end
			SH_DR: begin
				if (bypass) begin
					r_d.dr_sh = {{(DR_W-1){1'b0}}, lnk.tdi};
				end else begin
					r_d.dr_sh = {lnk.tdi, r_q.dr_sh[DR_W-1:1]};
				end
			end
			default: begin
			end
		endcase
	end

	always_comb begin
		f_d         = f_q;
		f_d.upd_stb = 1'b0;
		// TMS was taken half a cycle earlier, so it is settled here
		f_d.st = tap_next(f_q.st, r_q.tms);
		if (f_q.st == TAP_RESET) begin
			f_d.ir = INS_IDCODE;
		end else if (f_q.st == UPD_IR) begin
			f_d.ir = r_q.ir_sh;
		end
		if ((f_q.st == UPD_DR) && (f_q.ir == INS_USER)) begin
			f_d.upd     = r_q.dr_sh;
			f_d.upd_stb = 1'b1;
		end
		f_d.oe = (f_d.st == SH_DR) || (f_d.st == SH_IR);
		if (f_d.st == SH_IR) begin
			f_d.tdo = r_q.ir_sh[0];
		end else if (f_d.st == SH_DR) begin
			f_d.tdo = r_q.dr_sh[0];
		end
	end

	// Both halves clear on test reset alone, no edge needed
	always_ff @(posedge lnk.tck or negedge lnk.trst_n) begin
		if (!lnk.trst_n) begin
			r_q <= RISE_RST;
		end else begin
			r_q <= r_d;
		end
	end

	always_ff @(negedge lnk.tck or negedge lnk.trst_n) begin
		if (!lnk.trst_n) begin
			f_q <= FALL_RST;
		end else begin
			f_q <= f_d;
		end
	end

	assign lnk.tdo_d   = f_q.tdo;
	assign lnk.tdo_oe  = f_q.oe;
	assign o_user_data = f_q.upd;
	assign o_user_stb  = f_q.upd_stb;
	assign o_ir        = f_q.ir;
	assign o_tap_state = f_q.st;

endmodule // jtp_dev_end

//--- jtp_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
// Assumes one clock for both sides; depth is a power of two.
`timescale 1ns/1ps
module jtp_fifo
	import jtp_pkg::*;
#(
	parameter int W = CMD_W,
	parameter int D = FIFO_DEPTH
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst_n,
	input  wire logic         i_in_valid,
	output logic              o_in_ready,
	input  wire logic [W-1:0] i_in_data,
	output logic              o_out_valid,
	input  wire logic         i_out_ready,
	output logic [W-1:0]      o_out_data
);
	localparam int AW = $clog2(D);

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0]       wr;
		logic [AW-1:0]       rd;
		logic [AW:0]         cnt;
	} jtp_fifo_t;

	jtp_fifo_t f_q;
	jtp_fifo_t f_d;
	logic      push;
	logic      pop;

	assign o_in_ready  = (f_q.cnt != (AW+1)'(D));
	assign o_out_valid = (f_q.cnt != '0);
	assign o_out_data  = f_q.mem[f_q.rd];
	assign push        = i_in_valid && o_in_ready;
	assign pop         = o_out_valid && i_out_ready;

	always_comb begin
		f_d = f_q;
		if (push) begin
			f_d.mem[f_q.wr] = i_in_data;
			f_d.wr          = f_q.wr + 1'b1;
		end
		if (pop) begin
			f_d.rd = f_q.rd + 1'b1;
		end
		f_d.cnt = f_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			f_q <= '0;
		end else begin
			f_q <= f_d;
		end
	end
endmodule // jtp_fifo

//--- jtp_host_end.sv
// Host end: queues scan commands and bit-bangs the test link.
// Assumes TCK is made here by dividing the reference clock;
// TDO is brought in through two flip-flops before use.
`timescale 1ns/1ps
module jtp_host_end
	import jtp_pkg::*;
#(
	parameter int TCK_HALF = TCK_HALF_CYC,
	parameter bit HAS_TRST = 1'b1
) (
	input  wire logic            i_ref_clk,
	input  wire logic            i_rst_n,
	jtp_link_if.host             lnk,
	input  wire logic            i_cmd_valid,
	output logic                 o_cmd_ready,
	input  wire logic [OP_W-1:0] i_cmd_op,
	input  wire logic [DR_W-1:0] i_cmd_data,
	output logic                 o_rsp_valid,
	output logic [DR_W-1:0]      o_rsp_data,
	output logic                 o_busy
);

	typedef enum logic [1:0] {
		H_IDLE  = 2'b00,
		H_HEAD  = 2'b01,
		H_SHIFT = 2'b10,
		H_TAIL  = 2'b11
	} jtp_hst_t;

	typedef struct packed {
		logic [7:0]       div;
		logic             tck;
		logic             tms;
		logic             tdi;
		logic             trst_n;
		logic             tdo_s1;
		logic             tdo_s2;
		jtp_hst_t         st;
		logic             armed;
		logic [OP_W-1:0]  op;
		logic [7:0]       pat;
		logic [CNT_W-1:0] cnt;
		logic [DR_W-1:0]  tx;
		logic [DR_W-1:0]  rx;
		logic             rsp_valid;
		logic [DR_W-1:0]  rsp_data;
	} jtp_host_t;

	jtp_host_t        h_q;
	jtp_host_t        h_d;
	logic             q_valid;
	logic [CMD_W-1:0] q_data;
	logic             pop;
	logic             rise;
	logic             fall;

	jtp_fifo #(
		.W (CMD_W),
		.D (FIFO_DEPTH)
	) u_cmd_fifo (
		.i_clk       (i_ref_clk),
		.i_rst_n     (i_rst_n),
		.i_in_valid  (i_cmd_valid),
		.o_in_ready  (o_cmd_ready),
		.i_in_data   ({i_cmd_op, i_cmd_data}),
		.o_out_valid (q_valid),
		.i_out_ready (pop),
		.o_out_data  (q_data)
	);

	assign pop = q_valid && (h_q.st == H_IDLE);

	always_comb begin
		h_d           = h_q;
		h_d.rsp_valid = 1'b0;
		h_d.tdo_s1    = lnk.tdo;
		h_d.tdo_s2    = h_q.tdo_s1;
		rise          = 1'b0;
		fall          = 1'b0;
		if (h_q.div == 8'(TCK_HALF - 1)) begin
			h_d.div = '0;
			h_d.tck = ~h_q.tck;
			rise    = ~h_q.tck;
			fall    = h_q.tck;
		end else begin
			h_d.div = h_q.div + 8'h01;
		end
		if (pop) begin
			h_d.op    = q_data[CMD_W-1:DR_W];
			h_d.tx    = q_data[DR_W-1:0];
			h_d.st    = H_HEAD;
			h_d.armed = 1'b0;
			if (q_data[CMD_W-1:DR_W] == OP_RESET) begin
				h_d.pat = RST_TMS;
				h_d.cnt = RST_BITS;
			end else if (q_data[CMD_W-1:DR_W] == OP_IR) begin
				h_d.pat = IR_HEAD_TMS;
				h_d.cnt = IR_HEAD_BITS;
			end else begin
				h_d.pat = DR_HEAD_TMS;
				h_d.cnt = DR_HEAD_BITS;
			end
		end else if (fall) begin
			// New pin levels go out at falling TCK, settled by the rise
			h_d.armed = (h_q.st != H_IDLE);
			h_d.tdi   = 1'b0;
			case (h_q.st)
				H_IDLE: begin
					h_d.tms = 1'b0;
				end
				H_SHIFT: begin
					h_d.tms = (h_q.cnt == 6'h01);
					h_d.tdi = h_q.tx[0];
				end
				default: begin
					h_d.tms = h_q.pat[0];
				end
			endcase
			// Test reset rises while TMS is still driven high
			h_d.trst_n = !(HAS_TRST && (h_q.st == H_HEAD) && (h_q.op == OP_RESET)
				&& (h_q.cnt > TRST_REL_CNT));
		end else if (rise && h_q.armed) begin
			h_d.cnt = h_q.cnt - 6'h01;
			h_d.pat = {1'b0, h_q.pat[7:1]};
			case (h_q.st)
				H_HEAD: begin
					if (h_q.cnt == 6'h01) begin
						if (h_q.op == OP_RESET) begin
							h_d.st = H_IDLE;
						end else begin
							h_d.st  = H_SHIFT;
							h_d.cnt = (h_q.op == OP_IR) ? CNT_W'(IR_W) : CNT_W'(DR_W);
						end
					end
				end
				H_SHIFT: begin
					h_d.rx = {h_q.tdo_s2, h_q.rx[DR_W-1:1]};
					h_d.tx = {1'b0, h_q.tx[DR_W-1:1]};
					if (h_q.cnt == 6'h01) begin
						h_d.st  = H_TAIL;
						h_d.pat = TAIL_TMS;
						h_d.cnt = TAIL_BITS;
					end
				end
				H_TAIL: begin
					if (h_q.cnt == 6'h01) begin
						h_d.st        = H_IDLE;
						h_d.armed     = 1'b0;
						h_d.rsp_valid = 1'b1;
						h_d.rsp_data  = (h_q.op == OP_IR) ? (h_q.rx >> (DR_W - IR_W)) : h_q.rx;
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			h_q        <= '0;
			h_q.trst_n <= 1'b1;
		end else begin
			h_q <= h_d;
		end
	end

	assign lnk.tck     = h_q.tck;
	assign lnk.tms     = h_q.tms;
	assign lnk.tdi     = h_q.tdi;
	assign lnk.trst_n  = h_q.trst_n;
	assign o_rsp_valid = h_q.rsp_valid;
	assign o_rsp_data  = h_q.rsp_data;
	assign o_busy      = (h_q.st != H_IDLE);

endmodule // jtp_host_end

//--- jtp_link_assertions.sv
// Pin-level checks on the link between host end and device end.
// Assumes tck is made by the host and trst_n resets the device.
`timescale 1ns/1ps
module jtp_link_assertions
	import jtp_pkg::*;
(
	input wire logic     i_tck,
	input wire logic     i_tms,
	input wire logic     i_trst_n,
	input wire logic     i_tdo_d,
	input wire logic     i_tdo_oe,
	input wire jtp_tap_t i_tap_state
);
	wire jtp_tap_t st = i_tap_state;
	logic          tdo_r;
	jtp_tap_t      st_r;
	// Device state is unknown until the first test reset; checks wait for it
	logic          live = 1'b0;

	always @(negedge i_trst_n) begin
		live <= 1'b1;
	end

	// Values seen at rising tck must still stand just before falling tck
	always_ff @(posedge i_tck) begin
		tdo_r <= i_tdo_d;
		st_r  <= st;
	end

	default clocking cb @(posedge i_tck); endclocking
	default disable iff (!i_trst_n || !live);

	tdo_fall_a: assert property (@(negedge i_tck) i_tdo_d == tdo_r)
		else $error("TDO moved on rising TCK");
	state_fall_a: assert property (@(negedge i_tck) st == st_r)
		else $error("TAP moved on rising TCK");
	oe_shift_a: assert property (i_tdo_oe == (st == SH_DR || st == SH_IR))
		else $error("TDO enable outside shift");
	idle_sel_a: assert property (st == TAP_IDLE && i_tms |=> st == SEL_DR)
		else $error("Idle did not go to select");
	ir_path_a: assert property (st == SEL_DR && i_tms |=> st == SEL_IR)
		else $error("Select DR did not go to IR");
	shift_hold_a: assert property (st == SH_DR && !i_tms |=> st == SH_DR)
		else $error("Shift left early");
	exit_upd_a: assert property (st == EX1_IR && i_tms |=> st == UPD_IR)
		else $error("Exit did not go to update");
	upd_idle_a: assert property (st == UPD_DR && !i_tms |=> st == TAP_IDLE)
		else $error("Update did not go to idle");
	reset_hold_a: assert property (st == TAP_RESET && i_tms |=> st == TAP_RESET)
		else $error("Reset state left with TMS high");
	// Test reset overlaps the only run of five highs, so this one ignores it
	five_high_a: assert property (disable iff (!live) i_tms [*5] |=> st == TAP_RESET)
		else $error("Five TMS highs did not reset");

	cover property (st == SH_DR && i_tdo_oe);
	cover property (st == UPD_IR);
	cover property (disable iff (!live) i_tms [*5]);
endmodule // jtp_link_assertions

//--- jtp_link_if.sv
// Pin-level link between the test host and the device port.
// Assumes TDO idles at a weak pull-up level when released.
`timescale 1ns/1ps
interface jtp_link_if;
	logic tck;
	logic tms;
	logic tdi;
	logic trst_n;
	logic tdo_d;
	logic tdo_oe;
	wire  tdo;

	// Released pin reads high, as the pull-up would make it
	assign tdo = tdo_oe ? tdo_d : 1'b1;

	modport dev  (input tck, input tms, input tdi, input trst_n, output tdo_d, output tdo_oe);
	modport host (output tck, output tms, output tdi, output trst_n, input tdo);
endinterface : jtp_link_if

//--- jtp_pkg.sv
// Shared constants and types for the test access port link.
// Assumes both ends and the FIFO import this package whole.
package jtp_pkg;

	typedef enum logic [3:0] {
		TAP_RESET = 4'h0,
		TAP_IDLE  = 4'h1,
		SEL_DR    = 4'h2,
		CAP_DR    = 4'h3,
		SH_DR     = 4'h4,
		EX1_DR    = 4'h5,
		PAU_DR    = 4'h6,
		EX2_DR    = 4'h7,
		UPD_DR    = 4'h8,
		SEL_IR    = 4'h9,
		CAP_IR    = 4'hA,
		SH_IR     = 4'hB,
		EX1_IR    = 4'hC,
		PAU_IR    = 4'hD,
		EX2_IR    = 4'hE,
		UPD_IR    = 4'hF
	} jtp_tap_t;

	localparam int             IR_W       = 4;
	localparam int             DR_W       = 32;
	localparam logic [IR_W-1:0] INS_IDCODE = 4'h1;
	localparam logic [IR_W-1:0] INS_USER   = 4'h2;
	localparam logic [IR_W-1:0] INS_BYPASS = 4'hF;
	localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;

	// Host command word: op in the top bits, scan data below
	localparam int         OP_W      = 2;
	localparam int         CMD_W     = OP_W + DR_W;
	localparam logic [1:0] OP_RESET  = 2'h0;
	localparam logic [1:0] OP_IR     = 2'h1;
	localparam logic [1:0] OP_DR     = 2'h2;
	localparam int         FIFO_DEPTH = 8;

	// Host timing, in reference clock cycles per TCK half period, and host bit counter width
	localparam int TCK_HALF_CYC = 4;
	localparam int CNT_W        = 6;

	// TMS patterns, sent lsb first
	localparam logic [7:0]       RST_TMS      = 8'h1F;
	localparam logic [CNT_W-1:0] RST_BITS     = 6'h06;
	localparam logic [CNT_W-1:0] TRST_REL_CNT = 6'h03;
	localparam logic [7:0]       DR_HEAD_TMS  = 8'h01;
	localparam logic [CNT_W-1:0] DR_HEAD_BITS = 6'h03;
	localparam logic [7:0]       IR_HEAD_TMS  = 8'h03;
	localparam logic [CNT_W-1:0] IR_HEAD_BITS = 6'h04;
	localparam logic [7:0]       TAIL_TMS     = 8'h01;
	localparam logic [CNT_W-1:0] TAIL_BITS    = 6'h02;

endpackage : jtp_pkg

//--- test_jtag_tap_pin_interface.sv
// Bench joining host end and device end, plus a second device
// end driven directly with a 31 ns link clock and no host.
`timescale 1ns/1ps
module test_jtag_tap_pin_interface
	import jtp_pkg::*;
;
	localparam logic [DR_W-1:0] ID = 32'h1357_9BDF; // Arbitrary value
	logic            i_ref_clk;
	logic            i_rst_n;
	logic            cmd_v;
	logic            cmd_r;
	logic            rsp_v;
	logic            busy;
	logic            stb;
	logic [OP_W-1:0] cmd_op;
	logic [DR_W-1:0] cmd_d;
	logic [DR_W-1:0] rsp_d;
	logic [DR_W-1:0] ucap;
	logic [DR_W-1:0] udata;
	logic [DR_W-1:0] rq[$];
	logic [IR_W-1:0] ir;
	jtp_tap_t        st;
	jtp_tap_t        st_b;
	int              err_count;
	int              checks_done;
	int              stb_n;
	bit              full_seen;

	jtp_link_if lnk();
	jtp_link_if lnk_b();

	jtp_host_end jtp_host_end_i (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .lnk(lnk),
		.i_cmd_valid(cmd_v), .o_cmd_ready(cmd_r), .i_cmd_op(cmd_op), .i_cmd_data(cmd_d),
		.o_rsp_valid(rsp_v), .o_rsp_data(rsp_d), .o_busy(busy));
	jtp_dev_end #(.IDCODE_VAL(ID)) jtp_dev_end_i (.lnk(lnk), .i_user_capture(ucap),
		.o_user_data(udata), .o_user_stb(stb), .o_ir(ir), .o_tap_state(st));
	jtp_dev_end jtp_dev_end_b_i (.lnk(lnk_b), .i_user_capture(ucap), .o_user_data(),
		.o_user_stb(), .o_ir(), .o_tap_state(st_b));
	jtp_link_assertions jtp_link_assertions_i (.i_tck(lnk.tck), .i_tms(lnk.tms),
		.i_trst_n(lnk.trst_n), .i_tdo_d(lnk.tdo_d), .i_tdo_oe(lnk.tdo_oe), .i_tap_state(st));

	initial begin
		i_ref_clk = 0;
		forever #10 i_ref_clk = ~i_ref_clk;
	end

	// Responses may arrive while commands are still being offered
	always @(posedge i_ref_clk) if (rsp_v) rq.push_back(rsp_d);
	always @(posedge stb) stb_n++;

	task automatic end_sim();
		$display("checks %0d, mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [DR_W-1:0] g, input logic [DR_W-1:0] e, input string m);
		checks_done++;
		if (g !== e) begin
			$display("wrong value at %0t: %s", $time, m);
			err_count++;
		end
	endtask

	task automatic tmo();
		err_count++;
		$display("wrong value at %0t: wait ran out", $time);
		end_sim();
	endtask

	// Valid stays up between back-to-back calls; idle() drops it
	task automatic send(input logic [OP_W-1:0] op, input logic [DR_W-1:0] d);
		int n;
		n = 0;
		@(negedge i_ref_clk);
		cmd_v = 1;
		cmd_op = op;
		cmd_d = d;
		@(posedge i_ref_clk);
		while (!cmd_r) begin
			full_seen = 1;
			if (++n > 500) tmo();
			@(posedge i_ref_clk);
		end
	endtask

	task automatic idle();
		@(negedge i_ref_clk);
		cmd_v = 0;
	endtask

	task automatic get(output logic [DR_W-1:0] d);
		int n;
		n = 0;
		while (rq.size() == 0) begin
			if (++n > 3000) tmo();
			@(posedge i_ref_clk);
		end
		d = rq.pop_front();
	endtask

	// Update lands one falling tck after the response
	task automatic settle();
		repeat (12) @(negedge i_ref_clk);
	endtask

	task automatic t_reset();
		send(OP_RESET, '0);
		idle();
		repeat (70) @(negedge i_ref_clk);
		chk(DR_W'(st), DR_W'(TAP_IDLE), "tap not idle");
		chk(DR_W'(ir), DR_W'(INS_IDCODE), "ir not reset");
		chk(DR_W'(lnk.tdo_oe), '0, "tdo driven idle");
		chk(DR_W'(lnk.tdo), DR_W'(1'b1), "tdo not released");
		$display("done: reset");
	endtask

	task automatic t_idcode();
		logic [DR_W-1:0] d;
		send(OP_DR, '0);
		idle();
		@(negedge i_ref_clk);
		chk(DR_W'(busy), DR_W'(1'b1), "not busy in scan");
		get(d);
		chk(d, ID, "id word");
		chk(DR_W'(busy), '0, "busy after scan");
		$display("done: idcode");
	endtask

	task automatic t_user();
		logic [DR_W-1:0] d;
		int s;
		s = stb_n;
		ucap = 32'hC0DE_5A5A;
		send(OP_IR, DR_W'(INS_USER));
		send(OP_DR, 32'h2468_ACE1);
		idle();
		get(d);
		chk(DR_W'(d[IR_W-1:0]), DR_W'(IR_CAPTURE), "ir capture");
		get(d);
		chk(d, ucap, "user capture");
		settle();
		chk(udata, 32'h2468_ACE1, "user update");
		chk(DR_W'(stb_n), DR_W'(s + 1), "user strobe");
		chk(DR_W'(ir), DR_W'(INS_USER), "ir load");
		$display("done: user");
	endtask

	task automatic t_fifo();
		logic [DR_W-1:0] d;
		logic [DR_W-1:0] p;
		full_seen = 0;
		send(OP_IR, DR_W'(INS_BYPASS));
		for (int i = 0; i < 10; i++) send(OP_DR, 32'hF0E1_D2C3 ^ DR_W'(i << 3));
		idle();
		chk(DR_W'(full_seen), DR_W'(1'b1), "fifo never full");
		get(d);
		chk(DR_W'(d[IR_W-1:0]), DR_W'(IR_CAPTURE), "ir capture");
		for (int i = 0; i < 10; i++) begin
			p = 32'hF0E1_D2C3 ^ DR_W'(i << 3);
			get(d);
			chk(d, {p[DR_W-2:0], 1'b0}, "bypass data");
		end
		$display("done: fifo");
	endtask

	task automatic clk_b(input logic v);
		lnk_b.tms = v;
		#15 lnk_b.tck = 1;
		#15 lnk_b.tck = 0;
		#1;
	endtask

	task automatic t_b();
		lnk_b.trst_n = 0;
		#2 chk(DR_W'(st_b), DR_W'(TAP_RESET), "async reset");
		lnk_b.trst_n = 1;
		clk_b(1);
		chk(DR_W'(st_b), DR_W'(TAP_RESET), "left reset");
		clk_b(0);
		chk(DR_W'(st_b), DR_W'(TAP_IDLE), "no idle");
		clk_b(1);
		clk_b(0);
		clk_b(0);
		chk(DR_W'(st_b), DR_W'(SH_DR), "no shift");
		repeat (5) clk_b(1);
		chk(DR_W'(st_b), DR_W'(TAP_RESET), "no tms reset");
		$display("done: second end");
	endtask

	initial begin
		i_rst_n = 0;
		cmd_v = 0;
		cmd_op = '0;
		cmd_d = '0;
		ucap = '0;
		lnk_b.tck = 0;
		lnk_b.tms = 1;
		lnk_b.tdi = 0;
		lnk_b.trst_n = 1;
		repeat (6) @(negedge i_ref_clk);
		i_rst_n = 1;
		t_reset();
		t_idcode();
		t_user();
		t_fifo();
		t_b();
		end_sim();
	end
endmodule // test_jtag_tap_pin_interface
